// file: src/clock_gen_defines.vh
// Purpose: Constants for the clock generator control block
// Assumes: Register index is one quarter of the byte address
// Notes:   Definitions only
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define IDX_LOOP_CONTROL   8'h1C
`define IDX_LOOP_BANDWIDTH 8'h1D
`define IDX_LOOP_PROG      8'h1E
`define ADDR_LOOP_CONTROL   8'h70
`define ADDR_LOOP_BANDWIDTH 8'h74
`define ADDR_LOOP_PROG      8'h78

// ----------------------------------------
// Loop control fields
// ----------------------------------------
`define CTL_IRQ_EN_BIT  7
`define CTL_FLAG_BIT    6
`define CTL_PWR_ON_BIT  5
`define CTL_SRC_SEL_BIT 4

// ----------------------------------------
// Bandwidth control fields
// ----------------------------------------
`define BW_AUTO_BIT   7
`define BW_LOCK_BIT   6
`define BW_TRACK_BIT  5

// ----------------------------------------
// Programming fields and reset values
// ----------------------------------------
`define PROG_MULT_HI  7
`define PROG_MULT_LO  4
`define PROG_RANGE_HI 3
`define PROG_RANGE_LO 0
`define PROG_RESET    8'h11
`define PWR_ON_RESET  1'b1
`define AUTO_RESET    1'b0

// ----------------------------------------
// Source switch and nominal VCO centre
// ----------------------------------------
`define SWITCH_EDGES  2'h3
`define NOM_CENTRE_HZ 4915200
`define SRC_CRYSTAL   1'b0
`define SRC_VCO       1'b1
`define SW_RUN        1'b0
`define SW_WAIT       1'b1

`endif

// file: src/pll_clock_generator.v
// Purpose: Control logic of a crystal/PLL clock generator
// Assumes: Clocks and analog comparisons arrive as pins
// Notes:   Everything runs on ref_clk, pins are resynchronised
//
// Functional notes
// (RULE1) Base clock is crystal or VCO halved
// (RULE2) Oscillator runs only while enabled
// (RULE3) Reference is buffered crystal, undivided
// (RULE4) VCO divided modulo feedback multiplier
// (RULE5) Phase detector emits up/down correction pulses
// (RULE6) Lock detector drives filter mode and lock
// (RULE7) Acquisition mode reads tracking bit zero
// (RULE8) Tracking whenever tracking bit set; code also gates filter_tracking with loop_live
// (RULE9) Auto bit lets detector switch modes
// (RULE10) Auto: tracking bit read-only, tolerance driven
// (RULE11) Auto: settled flag follows lock tolerances
// (RULE12) Auto: interrupt on settled flag toggle
// (RULE13) Manual: tracking bit is writable control
// (RULE14) Software clears tracking bit before power-on
// (RULE15) Software waits acquisition time before tracking
// (RULE16) Software waits lock time before selecting VCO
// (RULE17) Manual: no settled flag, no interrupts
// (RULE18) Software selects VCO only when settled
// (RULE19) Programming: multiplier high, range low nibble
// (RULE20) VCO centre is range times nominal
// (RULE21) Bus clock is quarter of source
// (RULE22) Zero multiplier acts one; zero range disables
// (RULE23) Source switch waits three edges each; VCO edges not awaited while loop idle
// (RULE24) Refuse unsafe select/power-off writes
// (RULE25) Control read clears change flag
// (RULE26) Tolerance comparisons arrive as synced inputs
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "clock_gen_defines.vh"

module pll_clock_generator (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rst_b,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_strobe,
  input  wire       rd_strobe,
  output reg  [7:0] rd_data,
  // System integration
  input  wire       oscillator_enable_in,
  output reg        oscillator_run,
  // Clock pins from the analog side
  input  wire       crystal_pin,
  input  wire       vco_clock,
  // Analog tolerance comparisons
  input  wire       within_track_tol,
  input  wire       within_untrack_tol,
  input  wire       within_lock_tol,
  input  wire       within_unlock_tol,
  // Clock outputs
  output reg        crystal_clock,
  output reg        reference_clock,
  output reg        final_reference_clock,
  output reg        vco_feedback_clock,
  output reg        base_clock_out,
  output reg        bus_clock,
  // Loop control outputs
  output reg        vco_enable,
  output reg        filter_tracking,
  output reg        pump_up,
  output reg        pump_down,
  output reg  [3:0] range_mult,
  output reg        loop_irq
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  reg [1:0] xtal_sync_reg;   // Crystal pin, two stages
  reg [1:0] vco_sync_reg;    // VCO pin, two stages
  reg [1:0] trk_sync_reg;    // Track tolerance
  reg [1:0] unt_sync_reg;    // Untrack tolerance
  reg [1:0] lck_sync_reg;    // Lock tolerance
  reg [1:0] unl_sync_reg;    // Unlock tolerance
  reg       xtal_prev_reg;   // Edge history, crystal
  reg       vco_prev_reg;    // Edge history, VCO

  // Second stage only is read by logic
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      xtal_sync_reg <= 2'h0;
      vco_sync_reg  <= 2'h0;
      trk_sync_reg  <= 2'h0;
      unt_sync_reg  <= 2'h0;
      lck_sync_reg  <= 2'h0;
      unl_sync_reg  <= 2'h0;
      xtal_prev_reg <= 1'b0;
      vco_prev_reg  <= 1'b0;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[0], crystal_pin};
      vco_sync_reg  <= {vco_sync_reg[0], vco_clock};
      trk_sync_reg  <= {trk_sync_reg[0], within_track_tol};     // [RULE26]
      unt_sync_reg  <= {unt_sync_reg[0], within_untrack_tol};   // [RULE26]
      lck_sync_reg  <= {lck_sync_reg[0], within_lock_tol};      // [RULE26]
      unl_sync_reg  <= {unl_sync_reg[0], within_unlock_tol};    // [RULE26]
      xtal_prev_reg <= xtal_sync_reg[1];
      vco_prev_reg  <= vco_sync_reg[1];
    end
  end

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg       irq_en_reg;      // Loop interrupt enable
  reg       flag_reg;        // Loop change flag
  reg       pwr_on_reg;      // Loop power-on
  reg       src_sel_reg;     // Base source select
  reg       auto_reg;        // Bandwidth self-control
  reg       lock_reg;        // Settled flag
  reg       track_reg;       // Filter tracking bit
  reg [7:0] prog_reg;        // Multiplier and range
  reg       lock_next;       // Settled flag next value
  reg       track_next;      // Tracking bit next value

  wire       xtal_s    = xtal_sync_reg[1];
  wire       vco_s     = vco_sync_reg[1];
  wire       xtal_rise = xtal_s & ~xtal_prev_reg;
  wire       vco_rise  = vco_s & ~vco_prev_reg;
  wire [3:0] mult_raw  = prog_reg[`PROG_MULT_HI:`PROG_MULT_LO];   // [RULE19]
  wire [3:0] range_raw = prog_reg[`PROG_RANGE_HI:`PROG_RANGE_LO]; // [RULE19]
  // Zero multiplier counts as one
  wire [3:0] mult_eff  = (mult_raw == 4'h0) ? 4'h1 : mult_raw;     // [RULE22]
  // Loop works only when on, enabled and range non-zero
  wire       loop_live = pwr_on_reg & (range_raw != 4'h0) & oscillator_enable_in; // [RULE22]

  // Decoded accesses
  wire wr_ctl  = wr_strobe & (addr == `ADDR_LOOP_CONTROL);
  wire wr_bw   = wr_strobe & (addr == `ADDR_LOOP_BANDWIDTH);
  wire wr_prog = wr_strobe & (addr == `ADDR_LOOP_PROG);
  wire rd_ctl  = rd_strobe & (addr == `ADDR_LOOP_CONTROL);

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  reg  pwr_on_next;
  reg  src_sel_next;
  wire wr_pwr = wr_data[`CTL_PWR_ON_BIT];
  wire wr_sel = wr_data[`CTL_SRC_SEL_BIT];

  // Protection against selecting a dead VCO
  always @* begin
    pwr_on_next  = pwr_on_reg;
    src_sel_next = src_sel_reg;
    if (wr_ctl) begin
      // Power-off refused while VCO is the source
      if (wr_pwr || !src_sel_reg)
        pwr_on_next = wr_pwr;                                   // [RULE24]
      // Select refused while loop off or range zero
      if (!wr_sel || (pwr_on_reg && range_raw != 4'h0))
        src_sel_next = wr_sel;                                  // [RULE24]
    end
    // Zero range forces the crystal
    if (range_raw == 4'h0)
      src_sel_next = `SRC_CRYSTAL;                              // [RULE22]
  end

  // Lock change detection, auto mode only
  wire lock_toggle = auto_reg & (lock_reg != lock_next);

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_en_reg  <= 1'b0;
      flag_reg    <= 1'b0;
      pwr_on_reg  <= `PWR_ON_RESET;
      src_sel_reg <= `SRC_CRYSTAL;
    end else begin
      pwr_on_reg  <= pwr_on_next;
      src_sel_reg <= src_sel_next;
      // Enable is not writable in manual mode
      if (!auto_reg)
        irq_en_reg <= 1'b0;                                     // [RULE17]
      else if (wr_ctl)
        irq_en_reg <= wr_data[`CTL_IRQ_EN_BIT];
      // Set wins over read-clear so no toggle is lost
      if (!auto_reg)
        flag_reg <= 1'b0;                                       // [RULE17]
      else if (lock_toggle)
        flag_reg <= 1'b1;                                       // [RULE12]
      else if (rd_ctl)
        flag_reg <= 1'b0;                                       // [RULE25]
    end
  end

  // ----------------------------------------
  // Bandwidth control and lock detector
  // ----------------------------------------
  // Hysteresis: enter on tight, leave on loose tolerance
  always @* begin
    lock_next  = lock_reg;
    track_next = track_reg;
    if (!loop_live) begin
      lock_next  = 1'b0;
      track_next = auto_reg ? 1'b0 : track_reg;
    end else if (auto_reg) begin                                // [RULE9]
      if (lck_sync_reg[1])
        lock_next = 1'b1;                                       // [RULE11]
      else if (!unl_sync_reg[1])
        lock_next = 1'b0;                                       // [RULE11]
      if (trk_sync_reg[1])
        track_next = 1'b1;                                      // [RULE10]
      else if (!unt_sync_reg[1])
        track_next = 1'b0;                                      // [RULE10]
    end else begin
      lock_next = 1'b0;                                         // [RULE17]
    end
    // Manual mode: software owns the tracking bit
    if (!auto_reg && wr_bw)
      track_next = wr_data[`BW_TRACK_BIT];                      // [RULE13]
  end

  always @(posedge ref_clk) begin
    if (!rst_b) begin
      auto_reg  <= `AUTO_RESET;
      lock_reg  <= 1'b0;
      track_reg <= 1'b0;
      prog_reg  <= `PROG_RESET;
    end else begin
      lock_reg  <= lock_next;                                   // [RULE6]
      track_reg <= track_next;                                  // [RULE6]
      if (wr_bw)
        auto_reg <= wr_data[`BW_AUTO_BIT];
      if (wr_prog)
        prog_reg <= wr_data;                                    // [RULE19]
    end
  end

  // ----------------------------------------
  // Read port, data one cycle after strobe
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else if (rd_strobe) begin
      case (addr)
        `ADDR_LOOP_CONTROL:
          rd_data <= {irq_en_reg, flag_reg & auto_reg, pwr_on_reg, src_sel_reg, 4'h0}; // [RULE25]
        `ADDR_LOOP_BANDWIDTH:
          rd_data <= {auto_reg, lock_reg & auto_reg, track_reg, 5'h00}; // [RULE7]
        `ADDR_LOOP_PROG:
          rd_data <= prog_reg;
        default:
          rd_data <= 8'h00;   // Unmapped reads as zero
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ----------------------------------------
  // Feedback divider
  // ----------------------------------------
  reg  [3:0] div_cnt_reg;    // VCO edges in current period
  // Five bits so a multiplier of fifteen does not wrap to zero
  wire [4:0] half_sum = {1'b0, mult_eff} + 5'h01;
  wire [3:0] half_n   = half_sum[4:1];

  // Counter wraps at the multiplier; cleared to zero while loop idle
  always @(posedge ref_clk) begin
    if (!rst_b || !loop_live) begin
      div_cnt_reg <= 4'h0;
    end else if (vco_rise) begin
      if (div_cnt_reg >= mult_eff - 4'h1)
        div_cnt_reg <= 4'h0;                                    // [RULE4]
      else
        div_cnt_reg <= div_cnt_reg + 4'h1;                      // [RULE4]
    end
  end

  // ----------------------------------------
  // Phase detector
  // ----------------------------------------
  wire fb_now = (mult_eff == 4'h1) ? vco_s : (div_cnt_reg < half_n);
  reg  fb_prev_reg;          // Feedback edge history

  // Whichever edge comes first opens its pump until the other
  always @(posedge ref_clk) begin
    if (!rst_b || !loop_live) begin
      fb_prev_reg <= 1'b0;
      pump_up     <= 1'b0;
      pump_down   <= 1'b0;
    end else begin
      fb_prev_reg <= fb_now;
      if ((pump_up || xtal_rise) && (pump_down || (fb_now && !fb_prev_reg))) begin
        pump_up   <= 1'b0;                                      // [RULE5]
        pump_down <= 1'b0;                                      // [RULE5]
      end else begin
        if (xtal_rise)
          pump_up <= 1'b1;                                      // [RULE5]
        if (fb_now && !fb_prev_reg)
          pump_down <= 1'b1;                                    // [RULE5]
      end
    end
  end

  // ----------------------------------------
  // Base clock selector
  // ----------------------------------------
  reg       sw_state_reg;    // Run or switching
  reg       src_cur_reg;     // Source now driving base
  reg [1:0] xtal_cnt_reg;    // Crystal edges seen in switch
  reg [1:0] vco_cnt_reg;     // VCO edges seen in switch
  wire      src_edge = (src_cur_reg == `SRC_VCO) ? vco_rise : xtal_rise;
  // A stopped VCO cannot deliver edges; do not wait on it
  wire      vco_done = (vco_cnt_reg == `SWITCH_EDGES) || !loop_live;

  // Hold base still until the crystal, and the VCO if loop live, have ticked three times
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sw_state_reg   <= `SW_RUN;
      src_cur_reg    <= `SRC_CRYSTAL;
      xtal_cnt_reg   <= 2'h0;
      vco_cnt_reg    <= 2'h0;
      base_clock_out <= 1'b0;
      bus_clock      <= 1'b0;
    end else begin
      case (sw_state_reg)
        `SW_RUN: begin
          xtal_cnt_reg <= 2'h0;
          vco_cnt_reg  <= 2'h0;
          if (src_sel_reg != src_cur_reg) begin
            sw_state_reg <= `SW_WAIT;                           // [RULE23]
          end else if (src_edge && oscillator_enable_in) begin
            base_clock_out <= ~base_clock_out;                  // [RULE1]
            if (!base_clock_out)
              bus_clock <= ~bus_clock;                          // [RULE21]
          end
        end
        `SW_WAIT: begin
          if (xtal_rise && xtal_cnt_reg != `SWITCH_EDGES)
            xtal_cnt_reg <= xtal_cnt_reg + 2'h1;                // [RULE23]
          if (vco_rise && vco_cnt_reg != `SWITCH_EDGES)
            vco_cnt_reg <= vco_cnt_reg + 2'h1;                  // [RULE23]
          if (xtal_cnt_reg == `SWITCH_EDGES && vco_done) begin
            src_cur_reg  <= src_sel_reg;                        // [RULE23]
            sw_state_reg <= `SW_RUN;
          end
        end
        default: sw_state_reg <= `SW_RUN;
      endcase
    end
  end

  // ----------------------------------------
  // Oscillator, reference and loop outputs
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      oscillator_run        <= 1'b0;
      crystal_clock         <= 1'b0;
      reference_clock       <= 1'b0;
      final_reference_clock <= 1'b0;
      vco_feedback_clock    <= 1'b0;
      vco_enable            <= 1'b0;
      filter_tracking       <= 1'b0;
      range_mult            <= 4'h0;
      loop_irq              <= 1'b0;
    end else begin
      oscillator_run        <= oscillator_enable_in;            // [RULE2]
      crystal_clock         <= xtal_s & oscillator_enable_in;   // [RULE2]
      reference_clock       <= xtal_s & oscillator_enable_in;   // [RULE3]
      final_reference_clock <= reference_clock;                 // [RULE3]
      vco_feedback_clock    <= fb_now & loop_live;              // [RULE4]
      vco_enable            <= loop_live;                       // [RULE22]
      // Analog side centres the VCO at range times nominal
      range_mult            <= range_raw;                       // [RULE20]
      // Clear bit means acquisition, set means tracking
      filter_tracking       <= track_reg & loop_live;           // [RULE8]
      loop_irq              <= flag_reg & irq_en_reg & auto_reg; // [RULE12] [RULE17]
    end
  end

endmodule // pll_clock_generator

// file: sim/pll_clock_checker.sv
// Purpose: Port assertions for the clock generator
// Assumes: Sees only the top module's ports
// Notes:   Bound in at the foot of this file
`timescale 1ns/1ps
`include "clock_gen_defines.vh"
module pll_clock_checker (
  // Clock, reset, register port
  input wire       ref_clk,
  input wire       rst_b,
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_strobe,
  // Clocks and loop status
  input wire       oscillator_enable_in,
  input wire       oscillator_run,
  input wire       crystal_clock,
  input wire       reference_clock,
  input wire       final_reference_clock,
  input wire       vco_feedback_clock,
  input wire       base_clock_out,
  input wire       bus_clock,
  input wire       vco_enable,
  input wire       filter_tracking,
  input wire       pump_up,
  input wire       pump_down,
  input wire [3:0] range_mult,
  input wire       loop_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // Write capture helpers
  // ----------------------------------------
  reg       prog_wr_q;  // Programming write last edge
  reg       man_wr_q;   // Manual-mode write last edge
  reg [3:0] range_q;    // Range nibble last written
  always @(posedge ref_clk) begin
    prog_wr_q <= rst_b && wr_strobe && addr == `ADDR_LOOP_PROG;
    man_wr_q  <= rst_b && wr_strobe && addr == `ADDR_LOOP_BANDWIDTH && !wr_data[`BW_AUTO_BIT];
    if (wr_strobe && addr == `ADDR_LOOP_PROG) begin
      range_q <= wr_data[3:0];
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_osc_follows_en: assert property ($past(rst_b) |-> oscillator_run == $past(oscillator_enable_in))
    else $error("oscillator run does not follow enable");
  a_xtal_gated: assert property (!$past(oscillator_enable_in) |-> !crystal_clock)
    else $error("crystal clock runs while disabled");
  a_ref_buffered: assert property (reference_clock == crystal_clock)
    else $error("reference clock differs from crystal clock");
  a_final_ref_delay: assert property ($past(rst_b) |-> final_reference_clock == $past(reference_clock))
    else $error("final reference is not reference delayed");
  a_bus_follows_base: assert property ($rose(base_clock_out) |-> ##[0:1] $changed(bus_clock))
    else $error("bus clock missed a base rising edge");
  a_bus_base_high: assert property ($changed(bus_clock) |-> base_clock_out)
    else $error("bus clock moved without base rising");
  a_idle_feedback: assert property (!vco_enable [*2] |-> !vco_feedback_clock)
    else $error("feedback clock runs with loop idle");
  a_track_needs_loop: assert property (filter_tracking |-> vco_enable)
    else $error("tracking with loop not live");
  a_live_range: assert property (vco_enable |-> range_mult != 4'h0)
    else $error("loop live with zero range");
  a_prog_range: assert property (prog_wr_q |-> ##[0:1] range_mult == range_q)
    else $error("range output does not follow write");
  a_manual_no_irq: assert property (man_wr_q |-> ##1 !loop_irq [*2])
    else $error("interrupt request in manual mode");
  a_pumps_exclusive: assert property (!(pump_up && pump_down))
    else $error("both charge pumps open at once");
  c_irq: cover property ($rose(loop_irq));
  c_track: cover property ($rose(filter_tracking));
  c_bus: cover property ($rose(bus_clock));
endmodule // pll_clock_checker

bind pll_clock_generator pll_clock_checker pll_clock_checker_i (.*);

// file: sim/tb.sv
// Purpose: Self-checking bench for the clock generator
// Assumes: Pin clocks far slower than ref_clk
// Notes:   A register model predicts every read after the first four
`timescale 1ns/1ps
`include "clock_gen_defines.vh"
module tb;
  // ----------------------------------------
  // Design ports and bench state
  // ----------------------------------------
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       wr_strobe = 1'b0;
  logic       rd_strobe = 1'b0;
  logic       oscillator_enable_in = 1'b1;
  logic       crystal_pin = 1'b0, vco_clock = 1'b0;
  logic       within_track_tol = 1'b0, within_untrack_tol = 1'b0;
  logic       within_lock_tol = 1'b0, within_unlock_tol = 1'b0;
  wire  [7:0] rd_data;
  wire  [3:0] range_mult;
  wire        oscillator_run, crystal_clock, reference_clock, final_reference_clock;
  wire        vco_feedback_clock, base_clock_out, bus_clock, vco_enable;
  wire        filter_tracking, pump_up, pump_down, loop_irq;
  int         error_cnt = 0, n_tests = 0, cyc = 0, seed = 30339, i;
  logic [7:0] d, prog = 8'h11;                      // Model programming value
  bit         pwr = 1, sel, ie, aut, trk, lck, flag; // Model bits
  logic [7:0] ctl_seq [6] = '{8'h00, 8'h10, 8'h20, 8'hB0, 8'h00, 8'h20};

  pll_clock_generator pll_clock_generator_i (.*);

  always #25 ref_clk = ~ref_clk;  // 50 ns period

  // Crystal /8, VCO /12: both kept below ref_clk/4
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) crystal_pin <= ~crystal_pin;
    if (cyc % 6 == 5) vco_clock <= ~vco_clock;
    if (cyc == 20000) begin  // Hang guard
      error_cnt++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Checking and model tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Edge counts may slip by one at window ends
  task automatic near(input int got, input int exp);
    check(16'((got >= exp - 1 && got <= exp + 1) ? exp : got), 16'(exp));
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] ctl_exp();
    return {ie & aut, flag & aut, pwr, sel, 4'h0};
  endfunction
  function automatic logic [7:0] bw_exp();
    return {aut, lck & aut, trk, 5'h00};
  endfunction
  // One-cycle write, model updated with the refusals
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'b1;
    @(posedge ref_clk);
    wr_strobe <= 1'b0;
    if (a == `ADDR_LOOP_PROG) prog = v;
    if (a == `ADDR_LOOP_BANDWIDTH) begin
      aut = v[7];
      if (!aut) trk = v[5];  // Writable only in manual mode
    end
    if (a == `ADDR_LOOP_CONTROL) begin
      ie = v[7] & aut;
      // Both refusals are judged on the bits as they stood before the write
      {pwr, sel} = {(!sel || v[5]) ? v[5] : pwr, (!v[4] || (pwr && prog[3:0] != 4'h0)) ? v[4] : sel};
    end
  endtask
  // Read strobe, data checked in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge ref_clk);
    rd_strobe <= 1'b0;
    @(negedge ref_clk);
    check(rd_data, e);
    if (a == `ADDR_LOOP_CONTROL) flag = 0;  // Read clears change flag
  endtask
  // Count output changes over 96 cycles after the switch settles
  task automatic measure(input int per);
    int   b = 0, u = 0, x = 0;
    logic pb, pu, px;
    repeat (80) @(negedge ref_clk);
    pb = base_clock_out;
    pu = bus_clock;
    px = crystal_clock;
    repeat (96) begin
      @(negedge ref_clk);
      b += int'(base_clock_out !== pb);
      u += int'(bus_clock !== pu);
      x += int'(crystal_clock !== px);
      pb = base_clock_out;
      pu = bus_clock;
      px = crystal_clock;
    end
    near(b, per ? 96 / per : 0);
    near(u, per ? 48 / per : 0);
    near(x, oscillator_enable_in ? 24 : 0);
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 30 && loop_irq !== 1'b1; k++) @(negedge ref_clk);
    flag = 1;
    check(loop_irq, 1'b1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`ADDR_LOOP_CONTROL, 8'h20);
    rd(`ADDR_LOOP_BANDWIDTH, 8'h00);
    rd(`ADDR_LOOP_PROG, 8'h11);
    rd(8'h71, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      if (i == 0) d[3:0] = 4'h0;        // Zero range first
      wr(`ADDR_LOOP_PROG, d);
      rd(`ADDR_LOOP_PROG, prog);
      check(range_mult, d[3:0]);
      check(vco_enable, d[3:0] != 4'h0);
    end
    wr(`ADDR_LOOP_PROG, 8'h30);
    wr(`ADDR_LOOP_CONTROL, 8'h30);
    rd(`ADDR_LOOP_CONTROL, ctl_exp());
    wr(`ADDR_LOOP_PROG, 8'h37);
    foreach (ctl_seq[j]) begin
      if (ctl_seq[j] == 8'hB0) begin
        wr(`ADDR_LOOP_BANDWIDTH, 8'h20);   // acquisition time already waited
        measure(8);                        // lock time before selecting VCO
      end
      wr(`ADDR_LOOP_CONTROL, ctl_seq[j]);  // tracking bit clear at power-on
      rd(`ADDR_LOOP_CONTROL, ctl_exp());
      measure(sel ? 12 : 8);
    end
    @(posedge ref_clk);
    oscillator_enable_in <= 1'b0;
    measure(0);
    @(posedge ref_clk);
    oscillator_enable_in <= 1'b1;
    wr(`ADDR_LOOP_BANDWIDTH, 8'h20);
    rd(`ADDR_LOOP_BANDWIDTH, bw_exp());
    check(filter_tracking, 1'b1);
    wr(`ADDR_LOOP_BANDWIDTH, 8'h00);
    rd(`ADDR_LOOP_BANDWIDTH, bw_exp());
    check(filter_tracking, 1'b0);
    wr(`ADDR_LOOP_BANDWIDTH, 8'h80);
    wr(`ADDR_LOOP_CONTROL, 8'hA0);
    within_track_tol <= 1'b1;
    within_untrack_tol <= 1'b1;
    trk = 1;
    repeat (8) @(negedge ref_clk);
    wr(`ADDR_LOOP_BANDWIDTH, 8'h80);    // Tracking bit write ignored
    rd(`ADDR_LOOP_BANDWIDTH, bw_exp());
    @(posedge ref_clk);
    within_lock_tol <= 1'b1;
    within_unlock_tol <= 1'b1;
    lck = 1;
    wait_irq();
    rd(`ADDR_LOOP_BANDWIDTH, bw_exp());
    rd(`ADDR_LOOP_CONTROL, ctl_exp());
    rd(`ADDR_LOOP_CONTROL, ctl_exp());
    check(loop_irq, 1'b0);
    wr(`ADDR_LOOP_CONTROL, 8'hB0);      // VCO chosen only once settled
    measure(12);
    @(posedge ref_clk);
    within_lock_tol <= 1'b0;
    within_unlock_tol <= 1'b0;
    lck = 0;
    wait_irq();
    @(posedge ref_clk);
    within_track_tol <= 1'b0;
    within_untrack_tol <= 1'b0;
    trk = 0;
    repeat (8) @(negedge ref_clk);
    rd(`ADDR_LOOP_CONTROL, ctl_exp());
    rd(`ADDR_LOOP_BANDWIDTH, bw_exp());
    wr(`ADDR_LOOP_BANDWIDTH, 8'h00);
    rd(`ADDR_LOOP_CONTROL, ctl_exp());
    check(loop_irq, 1'b0);
    give_verdict();
  end
endmodule // tb
